// file: rtl/iofd_top.sv
// Fault supervision and diagnosis entry generation for an eight-port IO-Link master.
`timescale 1ns/1ps
`include "iofd_defines.svh"
module iofd_top #(
	parameter int TICK_CYCLES = `IOFD_TICK_CYCLES,
	parameter int FILT_MS = `IOFD_FILT_MS,
	parameter int RETRY_MS = `IOFD_RETRY_MS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Fault pins
	input wire logic sup_fault_pin,
	input wire logic aux_fault_pin,
	input wire logic [7:0] sens_short_pin,
	input wire logic [7:0] drv_otemp_pin,
	input wire logic [7:0] sw_fault_pin,
	input wire logic [3:0] sec_actual_pin,
	// Commanded states
	input wire logic [7:0] digital_io_port_mode,
	input wire logic [7:0] switching_line_channel,
	input wire logic [3:0] second_line_channel,
	// Diagnosis entries
	output logic diag_valid,
	input wire logic diag_ready,
	output logic diag_appear,
	output logic [15:0] diag_chan,
	output logic [15:0] diag_code,
	// Drivers and indicators
	output logic [7:0] sw_out_en,
	output logic [3:0] sec_out_en,
	output logic sup_led_on,
	output logic aux_led_red,
	output logic [3:0] ch_led_red,
	output logic map_mode,
	output logic [47:0] pd_in_len,
	output logic [47:0] pd_out_len
);
	import iofd_pkg::*;
	localparam int NPIN = 30;
	localparam int NSRC = 22;
	localparam logic [7:0] RETRY8 = 8'(RETRY_MS);

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, f_q;
	logic f_sup, f_aux;
	logic [7:0] f_sens, f_otemp, f_sw;
	logic [3:0] f_sec;
	assign pin_raw = {sec_actual_pin, sw_fault_pin, drv_otemp_pin, sens_short_pin, aux_fault_pin, sup_fault_pin};
	assign {f_sec, f_sw, f_otemp, f_sens, f_aux, f_sup} = f_q;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					f_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						f_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	// ***************************************************************
	// Millisecond tick
	// ***************************************************************
	logic [15:0] tick_cnt_q;
	logic tick_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// ***************************************************************
	// Register bus
	// ***************************************************************
	logic aw_have_q, w_have_q, wr_go;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aux_en_q;
	logic [7:0] mask_ms_q;
	logic [3:0] unlock_q;
	logic [3:0] err, lock;
	logic [7:0] sw_off_q;
	logic [31:0] rd_mux;

	function automatic logic is_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a < (`IOFD_ADDR_PD_BASE + 8'h20);
	endfunction

	function automatic iofd_pdlen_t clamp_len(input logic [5:0] v);
		if (v < `IOFD_PD_MIN) begin
			return `IOFD_PD_MIN;
		end
		if (v > `IOFD_PD_MAX) begin
			return `IOFD_PD_MAX;
		end
		return v;
	endfunction

	assign wr_go = aw_have_q && w_have_q && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_have_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else begin
			if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			awready <= !aw_have_q && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
			w_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_have_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else begin
			if (wr_go) begin
				w_have_q <= 1'b0;
			end
			wready <= !w_have_q && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `IOFD_RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= is_mapped(aw_addr_q) ? `IOFD_RESP_OKAY : `IOFD_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Configuration registers; reporting of the actuator supply starts disabled.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_en_q <= 1'b0;
			map_mode <= 1'b0;
			mask_ms_q <= `IOFD_MASK_RST;
			unlock_q <= 4'h0;
			pd_in_len <= {8{`IOFD_PD_MIN}};
			pd_out_len <= {8{`IOFD_PD_MIN}};
		end else begin
			unlock_q <= 4'h0;
			if (wr_go && w_strb_q[0] && aw_addr_q == `IOFD_ADDR_CTRL) begin
				aux_en_q <= w_data_q[`IOFD_CTRL_AUXEN];
				map_mode <= w_data_q[`IOFD_CTRL_MAP];
			end
			if (wr_go && w_strb_q[0] && aw_addr_q == `IOFD_ADDR_MASK) begin
				mask_ms_q <= w_data_q[7:0];
			end
			if (wr_go && w_strb_q[0] && aw_addr_q == `IOFD_ADDR_UNLOCK) begin
				unlock_q <= w_data_q[3:0];
			end
			for (int p = 0; p < 8; p++) begin
				if (wr_go && aw_addr_q == `IOFD_ADDR_PD_BASE + 8'(4 * p)) begin
					if (w_strb_q[0]) begin
						pd_in_len[6*p +: 6] <= clamp_len(w_data_q[`IOFD_PD_IN_LSB +: 6]);
					end
					if (w_strb_q[1]) begin
						pd_out_len[6*p +: 6] <= clamp_len(w_data_q[`IOFD_PD_OUT_LSB +: 6]);
					end
				end
			end
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (araddr)
			`IOFD_ADDR_CTRL: rd_mux = {30'h0, map_mode, aux_en_q};
			`IOFD_ADDR_MASK: rd_mux = {24'h0, mask_ms_q};
			`IOFD_ADDR_STATUS: rd_mux = {16'h0, sw_off_q, lock, 2'h0, f_aux, f_sup};
			default: begin
				for (int p = 0; p < 8; p++) begin
					if (araddr == `IOFD_ADDR_PD_BASE + 8'(4 * p)) begin
						rd_mux = {18'h0, pd_out_len[6*p +: 6], 2'h0, pd_in_len[6*p +: 6]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `IOFD_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= is_mapped(araddr) ? `IOFD_RESP_OKAY : `IOFD_RESP_SLVERR;
		end else begin
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			arready <= !rvalid;
		end
	end

	// ***************************************************************
	// Second-line output channels
	// ***************************************************************
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			iofd_chan #(.FILT_MS(FILT_MS)) u_chan (
				.clk(aclk),
				.rst_n(aresetn),
				.tick(tick_q),
				.mask_ms(mask_ms_q),
				.unlock(unlock_q[gi]),
				.target(second_line_channel[gi]),
				.actual(f_sec[gi]),
				.err_q(err[gi]),
				.lock_q(lock[gi])
			);
		end
	endgenerate

	// ***************************************************************
	// Switching-line outputs with automatic retry
	// ***************************************************************
	logic [7:0] retry_q [8];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_off_q <= 8'h00;
			sw_out_en <= 8'h00;
			for (int p = 0; p < 8; p++) begin
				retry_q[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < 8; p++) begin
				if (f_sw[p] && sw_out_en[p]) begin
					sw_off_q[p] <= 1'b1;
					retry_q[p] <= RETRY8;
				end else if (sw_off_q[p] && tick_q) begin
					if (retry_q[p] <= 8'h01) begin
						sw_off_q[p] <= 1'b0;
					end
					retry_q[p] <= retry_q[p] - 8'h01;
				end
			end
			sw_out_en <= switching_line_channel & ~sw_off_q & ~(f_sw & sw_out_en);
		end
	end

	// ***************************************************************
	// Indicators and second-line drivers
	// ***************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sup_led_on <= 1'b0;
			aux_led_red <= 1'b0;
			ch_led_red <= 4'h0;
			sec_out_en <= 4'h0;
		end else begin
			sup_led_on <= !f_sup;
			aux_led_red <= f_aux && aux_en_q;
			ch_led_red <= err | lock;
			sec_out_en <= second_line_channel & ~lock;
		end
	end

	// ***************************************************************
	// Diagnosis entries
	// ***************************************************************
	logic [NSRC-1:0] act, rep_q;
	iofd_diag_st_t st_q;
	logic found;
	logic [4:0] pick;

	assign act[0] = f_sup;
	assign act[1] = f_aux && aux_en_q;
	assign act[9:2] = f_sens;
	assign act[17:10] = digital_io_port_mode & (f_sw | ({8{f_aux}} & switching_line_channel));
	assign act[21:18] = err;

	function automatic logic [31:0] src_entry(input logic [4:0] i, input logic [7:0] ot);
		if (i == 5'd0) begin
			return {`IOFD_GRP_CH, `IOFD_CODE_US};
		end
		if (i == 5'd1) begin
			return {`IOFD_GRP_CH, `IOFD_CODE_AUX};
		end
		if (i < 5'd10) begin
			return {16'(i - 5'd1), ot[3'(i - 5'd2)] ? `IOFD_CODE_OTEMP : `IOFD_CODE_SENS};
		end
		if (i < 5'd18) begin
			return {16'(i - 5'd9), `IOFD_CODE_SWDO};
		end
		return {16'(i - 5'd13), `IOFD_CODE_SEC};
	endfunction

	// Lowest index wins so group diagnoses precede channel diagnoses.
	always_comb begin
		found = 1'b0;
		pick = 5'd0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (act[i] != rep_q[i]) begin
				found = 1'b1;
				pick = 5'(i);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= IOFD_DIAG_IDLE;
			rep_q <= '0;
			diag_valid <= 1'b0;
			diag_appear <= 1'b0;
			diag_chan <= 16'h0000;
			diag_code <= 16'h0000;
		end else begin
			case (st_q)
				IOFD_DIAG_IDLE: begin
					if (found) begin
						rep_q[pick] <= act[pick];
						diag_valid <= 1'b1;
						diag_appear <= act[pick];
						{diag_chan, diag_code} <= src_entry(pick, f_otemp);
						st_q <= IOFD_DIAG_SEND;
					end
				end
				IOFD_DIAG_SEND: begin
					if (diag_ready) begin
						diag_valid <= 1'b0;
						st_q <= IOFD_DIAG_IDLE;
					end
				end
				default: st_q <= IOFD_DIAG_IDLE;
			endcase
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sup_new;
		$rose(f_sup) && !diag_valid && !rep_q[0];
	endsequence
	sequence s_sup_entry;
		diag_valid && diag_appear && diag_chan == `IOFD_GRP_CH && diag_code == `IOFD_CODE_US;
	endsequence

	sup_diag_a: assert property (s_sup_new |=> s_sup_entry)
		else $error("supply fault did not raise its group diagnosis");
	sup_led_a: assert property (f_sup |=> !sup_led_on)
		else $error("supply indicator lit during supply fault");
	aux_gate_a: assert property (!aux_en_q |=> !aux_led_red)
		else $error("actuator indicator red while reporting disabled");
	diag_hold_a: assert property (diag_valid && !diag_ready |=> diag_valid && $stable(diag_code) && $stable(diag_chan))
		else $error("diagnosis entry dropped before acceptance");
	diag_once_a: assert property (diag_valid && diag_ready |=> !diag_valid)
		else $error("diagnosis entry repeated back to back");
	sw_off_a: assert property ((f_sw & sw_out_en) != 8'h00 |=> (sw_out_en & $past(f_sw) & $past(sw_out_en)) == 8'h00)
		else $error("faulted switching output not switched off");
	sec_lock_a: assert property (lock != 4'h0 |=> (sec_out_en & $past(lock)) == 4'h0)
		else $error("locked channel still driven");
	rd_answer_a: assert property (arvalid && arready |=> rvalid ##0 !arready)
		else $error("read not answered in one cycle");
endmodule

// file: pkg/iofd_defines.svh
// Offsets, field positions, reset values, diagnosis codes and timing counts of the IO fault diagnostics block.
`ifndef IOFD_DEFINES_SVH
`define IOFD_DEFINES_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define IOFD_CLK_HZ 20000000
`define IOFD_TICK_PERIOD_MS 1
`define IOFD_TICK_CYCLES ((`IOFD_CLK_HZ / 1000) * `IOFD_TICK_PERIOD_MS)
`define IOFD_MASK_RST 8'h50
`define IOFD_FILT_MS 5
`define IOFD_RETRY_MS 100

// ***************************************************************
// Diagnosis channels and codes
// ***************************************************************
`define IOFD_GRP_CH 16'h8000
`define IOFD_CODE_US 16'h0002
`define IOFD_CODE_AUX 16'h0103
`define IOFD_CODE_SENS 16'h0001
`define IOFD_CODE_OTEMP 16'h0113
`define IOFD_CODE_SWDO 16'h010a
`define IOFD_CODE_SEC 16'h0109

// ***************************************************************
// Register map
// ***************************************************************
`define IOFD_ADDR_CTRL 8'h00
`define IOFD_ADDR_MASK 8'h04
`define IOFD_ADDR_STATUS 8'h08
`define IOFD_ADDR_UNLOCK 8'h0c
`define IOFD_ADDR_PD_BASE 8'h10
`define IOFD_CTRL_AUXEN 0
`define IOFD_CTRL_MAP 1
`define IOFD_PD_IN_LSB 0
`define IOFD_PD_OUT_LSB 8
`define IOFD_PD_MIN 6'h01
`define IOFD_PD_MAX 6'h20
`define IOFD_RESP_OKAY 2'h0
`define IOFD_RESP_SLVERR 2'h2

`endif

// file: pkg/iofd_pkg.sv
// Types shared by the IO fault diagnostics block.
package iofd_pkg;
	typedef enum logic [0:0] {
		IOFD_DIAG_IDLE = 1'b0,
		IOFD_DIAG_SEND = 1'b1
	} iofd_diag_st_t;
	typedef logic [5:0] iofd_pdlen_t;
endpackage

// file: rtl/iofd_chan.sv
// Per-channel output error filter with edge mask, static filter and lock.
`timescale 1ns/1ps
`include "iofd_defines.svh"
module iofd_chan #(
	parameter int FILT_MS = `IOFD_FILT_MS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Timebase and configuration
	input wire logic tick,
	input wire logic [7:0] mask_ms,
	input wire logic unlock,
	// Channel state
	input wire logic target,
	input wire logic actual,
	// Results
	output logic err_q,
	output logic lock_q
);
	import iofd_pkg::*;
	localparam logic [7:0] FILT8 = 8'(FILT_MS);
	logic target_q;
	logic [7:0] mask_q;
	logic [7:0] filt_q;
	logic raw;
	logic edge_seen;

	assign raw = target & ~actual;
	assign edge_seen = target ^ target_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			target_q <= 1'b0;
		end else begin
			target_q <= target;
		end
	end

	// Every commanded edge restarts the mask time.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= 8'h00;
		end else if (edge_seen) begin
			mask_q <= mask_ms;
		end else if (tick && mask_q != 8'h00) begin
			mask_q <= mask_q - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filt_q <= 8'h00;
		end else if (edge_seen || !raw || mask_q != 8'h00) begin
			filt_q <= 8'h00;
		end else if (tick && filt_q != FILT8) begin
			filt_q <= filt_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			err_q <= 1'b0;
		end else begin
			err_q <= raw && !edge_seen && mask_q == 8'h00 && filt_q == FILT8;
		end
	end

	// The lock outlives the fault; only software releases it, and a new error wins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_q <= 1'b0;
		end else if (err_q) begin
			lock_q <= 1'b1;
		end else if (unlock) begin
			lock_q <= 1'b0;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	err_filtered_a: assert property ($rose(err_q) |-> $past(filt_q) == FILT8 && $past(mask_q) == 8'h00)
		else $error("channel error reported before filter and mask expired");
	edge_mask_a: assert property (edge_seen |=> mask_q == $past(mask_ms) && !err_q)
		else $error("edge did not load mask time");
	agree_quiet_a: assert property ((target == actual) |=> !err_q)
		else $error("error raised while target and actual agree");
	lock_keep_a: assert property ($rose(err_q) |=> lock_q ##1 (lock_q || $past(unlock)))
		else $error("channel lock not held after error");
endmodule

// file: dv/iofd_stack_model.sv
// Behavioural model of the fieldbus stack that takes diagnosis entries.
`timescale 1ns/1ps
module iofd_stack_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Diagnosis stream
	input wire logic diag_valid,
	input wire logic diag_appear,
	input wire logic [15:0] diag_chan,
	input wire logic [15:0] diag_code,
	output logic diag_ready,
	// Pacing
	input wire logic slow
);
	logic [32:0] got[$];
	logic [1:0] hold_q;

	// Entries are kept whole in arrival order; a slow stack stalls four cycles per entry.
	always @(posedge aclk) begin
		if (!aresetn) begin
			diag_ready <= 1'b0;
			hold_q <= 2'h0;
		end else if (diag_valid && diag_ready) begin
			got.push_back({diag_appear, diag_chan, diag_code});
			diag_ready <= 1'b0;
			hold_q <= 2'h0;
		end else if (diag_valid) begin
			hold_q <= hold_q + 2'h1;
			diag_ready <= !slow || hold_q == 2'h3;
		end
	end
endmodule

// file: dv/iofd_top_tb.sv
// Self-checking bench of the IO fault diagnostics block.
`timescale 1ns/1ps
`include "iofd_defines.svh"
module iofd_top_tb;
	logic aclk = 0, aresetn = 0, slow = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic sup_fault_pin = 0, aux_fault_pin = 0;
	logic [7:0] sens_short_pin = 0, drv_otemp_pin = 0, sw_fault_pin = 0;
	logic [7:0] digital_io_port_mode = 0, switching_line_channel = 0;
	logic [3:0] sec_actual_pin = 0, second_line_channel = 0;
	logic awready, wready, bvalid, arready, rvalid, diag_valid, diag_ready, diag_appear;
	logic sup_led_on, aux_led_red, map_mode;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] diag_chan, diag_code;
	logic [7:0] sw_out_en;
	logic [3:0] sec_out_en, ch_led_red;
	logic [47:0] pd_in_len, pd_out_len;
	int miscompares = 0, num_checks = 0, cycles = 0;

	always #25 aclk = ~aclk;

	iofd_top #(.TICK_CYCLES(10), .FILT_MS(3), .RETRY_MS(3)) DUT (
		.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .sup_fault_pin, .aux_fault_pin, .sens_short_pin, .drv_otemp_pin, .sw_fault_pin,
		.sec_actual_pin, .digital_io_port_mode, .switching_line_channel, .second_line_channel,
		.diag_valid, .diag_ready, .diag_appear, .diag_chan, .diag_code, .sw_out_en, .sec_out_en,
		.sup_led_on, .aux_led_red, .ch_led_red, .map_mode, .pd_in_len, .pd_out_len);

	iofd_stack_model model (.aclk, .aresetn, .diag_valid, .diag_appear, .diag_chan, .diag_code,
		.diag_ready, .slow);

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic test_done;
		if (miscompares == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ad, wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready && !ad) begin
				ad = 1;
				awvalid <= 0;
			end
			if (wready && !wd) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		chk(rdata, ex);
		chk(rresp, er);
	endtask

	task automatic exp_diag(input logic ap, input logic [15:0] ch, input logic [15:0] cd);
		logic [32:0] e;
		e = '1;
		for (int n = 0; n < 400 && model.got.size() == 0; n++) @(posedge aclk);
		if (model.got.size() != 0) e = model.got.pop_front();
		chk(e, {ap, ch, cd});
	endtask

	task automatic exp_none(input int n);
		repeat (n) @(posedge aclk);
		chk(model.got.size(), 0);
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_regs;
		rd(`IOFD_ADDR_CTRL, 0, `IOFD_RESP_OKAY);
		rd(`IOFD_ADDR_MASK, 32'h50, `IOFD_RESP_OKAY);
		rd(`IOFD_ADDR_PD_BASE, 32'h0101, `IOFD_RESP_OKAY);
		rd(8'h40, 0, `IOFD_RESP_SLVERR);
		wr(`IOFD_ADDR_PD_BASE + 8'h08, 32'h0021, 4'h3, `IOFD_RESP_OKAY);
		rd(`IOFD_ADDR_PD_BASE + 8'h08, 32'h0120, `IOFD_RESP_OKAY);
		wr(`IOFD_ADDR_PD_BASE + 8'h04, 32'h0c03, 4'h3, `IOFD_RESP_OKAY);
		rd(`IOFD_ADDR_PD_BASE + 8'h04, 32'h0c03, `IOFD_RESP_OKAY);
		wr(8'h44, 32'h1, 4'hf, `IOFD_RESP_SLVERR);
		wr(`IOFD_ADDR_CTRL, 32'h2, 4'h1, `IOFD_RESP_OKAY);
		@(posedge aclk);
		chk(map_mode, 1);
		chk(pd_in_len, 48'h0410410600c1);
		chk(pd_out_len, 48'h041041041301);
	endtask

	task automatic t_supply;
		digital_io_port_mode <= 8'h04;
		switching_line_channel <= 8'h04;
		repeat (10) @(posedge aclk);
		sup_fault_pin <= 1;
		exp_diag(1, `IOFD_GRP_CH, `IOFD_CODE_US);
		chk(sup_led_on, 0);
		chk(sw_out_en, 8'h04);
		sup_fault_pin <= 0;
		exp_diag(0, `IOFD_GRP_CH, `IOFD_CODE_US);
		exp_none(20);
		chk(sup_led_on, 1);
		digital_io_port_mode <= 0;
		switching_line_channel <= 0;
	endtask

	task automatic t_aux;
		aux_fault_pin <= 1;
		exp_none(30);
		chk(aux_led_red, 0);
		wr(`IOFD_ADDR_CTRL, 32'h3, 4'h1, `IOFD_RESP_OKAY);
		exp_diag(1, `IOFD_GRP_CH, `IOFD_CODE_AUX);
		chk(aux_led_red, 1);
		digital_io_port_mode <= 8'h01;
		switching_line_channel <= 8'h01;
		exp_diag(1, 16'h1, `IOFD_CODE_SWDO);
		aux_fault_pin <= 0;
		exp_diag(0, `IOFD_GRP_CH, `IOFD_CODE_AUX);
		exp_diag(0, 16'h1, `IOFD_CODE_SWDO);
		digital_io_port_mode <= 0;
		switching_line_channel <= 0;
	endtask

	task automatic t_sensor;
		slow <= 1;
		drv_otemp_pin <= 8'h04;
		sens_short_pin <= 8'h0c;
		exp_diag(1, 16'h3, `IOFD_CODE_OTEMP);
		exp_diag(1, 16'h4, `IOFD_CODE_SENS);
		sens_short_pin <= 0;
		exp_diag(0, 16'h3, `IOFD_CODE_OTEMP);
		exp_diag(0, 16'h4, `IOFD_CODE_SENS);
		drv_otemp_pin <= 0;
		slow <= 0;
	endtask

	task automatic t_switch;
		digital_io_port_mode <= 8'h02;
		switching_line_channel <= 8'h02;
		repeat (10) @(posedge aclk);
		chk(sw_out_en, 8'h02);
		sw_fault_pin <= 8'h02;
		exp_diag(1, 16'h2, `IOFD_CODE_SWDO);
		chk(sw_out_en, 8'h00);
		for (int n = 0; n < 100 && !sw_out_en[1]; n++) @(posedge aclk);
		chk(sw_out_en, 8'h02);
		sw_fault_pin <= 0;
		exp_diag(0, 16'h2, `IOFD_CODE_SWDO);
		digital_io_port_mode <= 0;
		switching_line_channel <= 0;
	endtask

	task automatic t_second;
		wr(`IOFD_ADDR_MASK, 32'h2, 4'h1, `IOFD_RESP_OKAY);
		sec_actual_pin <= 4'h2;
		second_line_channel <= 4'h3;
		exp_none(25);
		exp_diag(1, 16'h5, `IOFD_CODE_SEC);
		chk(ch_led_red, 4'h1);
		chk(sec_out_en, 4'h2);
		sec_actual_pin <= 4'h3;
		exp_diag(0, 16'h5, `IOFD_CODE_SEC);
		chk(sec_out_en, 4'h2);
		rd(`IOFD_ADDR_STATUS, 32'h10, `IOFD_RESP_OKAY);
		wr(`IOFD_ADDR_UNLOCK, 32'h1, 4'h1, `IOFD_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(sec_out_en, 4'h3);
		second_line_channel <= 0;
		sec_actual_pin <= 0;
		exp_none(60);
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		repeat (5) @(posedge aclk);
		t_regs();
		t_supply();
		t_aux();
		t_sensor();
		t_switch();
		t_second();
		test_done();
	end
endmodule
